// *** design/sac_conv_ctrl.sv ***
/*
 * sac_conv_ctrl: control of a 10-bit SAR converter behind an APB slave:
 * enable, sar clock divider, trigger select, tracking, busy and done,
 * result formatting.
 * Assumes timer overflow pulses and cmp_hi are synchronous to clk;
 * ext_convert_start is asynchronous and is synchronised here.
 */
// How it works
// - converter runs only while enable is set
// - enable clear forces idle, no conversions
// - each conversion loads result high and low
// - right justified code in low ten bits
// - left justified code in upper ten bits
// - unused result bits read as zero
// - eight-bit mode puts eight msbs high
// - eight-bit mode ignores left justify
// - eight-bit conversion takes two fewer ticks
// - sar clock is divided system clock
// - five-bit divider, rate clk over n+1
// - source field picks one of six
// - writing busy one starts sw conversion
// - selected timer overflow starts a conversion
// - external rising edge starts a conversion
// - timer 2/3 use low or high overflow
// - busy is one throughout each conversion
// - busy falling sets done, raises interrupt
// - delayed tracking waits three sar ticks
// - no delayed tracking starts at once
// - internal sources track whenever enabled and not converting
// - external source tracks per delay or pin
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        t0_ovf,
    input  wire logic        t1_ovf,
    input  wire logic        t2_lo_ovf,
    input  wire logic        t2_hi_ovf,
    input  wire logic        t2_split,
    input  wire logic        t3_lo_ovf,
    input  wire logic        t3_hi_ovf,
    input  wire logic        t3_split,
    input  wire logic        ext_convert_start,
    input  wire logic        cmp_hi,
    output logic [9:0]       dac_code,
    output logic             track,
    output logic             powered,
    output logic             conv_irq
);
    logic [1:0]         rst_pipe_q;
    logic               rst_n_q;
    logic               pready_q;
    logic [31:0]        prdata_q;
    logic               pslverr_q;
    logic               acc;
    logic               wr_fire;
    logic               wr_ctrl;
    logic               wr_cfg;
    logic               en_q;
    logic               dtrk_q;
    logic               irqen_q;
    logic [2:0]         src_q;
    logic               done_q;
    logic [4:0]         div_q;
    logic               lj_q;
    logic               eight_q;
    logic [7:0]         res_hi_q;
    logic [7:0]         res_lo_q;
    logic [15:0]        res_fmt;
    logic               ext_s1_q;
    logic               ext_s2_q;
    logic               ext_s3_q;
    logic               ext_rise;
    logic               t2_ovf;
    logic               t3_ovf;
    logic               sw_start;
    logic               trig;
    sac_pkg::sac_state_t st_q;
    logic [4:0]         div_cnt_q;
    logic               tick;
    logic [1:0]         dly_q;
    logic               core_go;
    logic               core_done;
    logic [9:0]         core_code;
    logic [9:0]         trial_q;
    logic               track_q;
    logic               irq_q;
    logic               busy;
    logic [7:0]         ctrl_rd;
    logic [7:0]         cfg_rd;

    // true for the four mapped register offsets
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == sac_pkg::OFF_CTRL) || (a == sac_pkg::OFF_CFG) ||
                  (a == sac_pkg::OFF_RES_HI) || (a == sac_pkg::OFF_RES_LO);
    endfunction

    // reset release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n_q = rst_pipe_q[1];

    // apb: one wait state, data and error registered
    assign acc     = psel && penable;
    assign wr_fire = acc && pready_q && pwrite && pstrb[0];
    assign wr_ctrl = wr_fire && (paddr == sac_pkg::OFF_CTRL);
    assign wr_cfg  = wr_fire && (paddr == sac_pkg::OFF_CFG);
    assign busy    = (st_q != sac_pkg::ST_IDLE);

    assign ctrl_rd = {en_q, dtrk_q, done_q, busy, irqen_q, src_q};
    assign cfg_rd  = {div_q, lj_q, eight_q, 1'b0};

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= acc && !pready_q;
            pslverr_q <= acc && !pready_q && !reg_hit(paddr);
            prdata_q  <= 32'h0;
            if (acc && !pready_q && !pwrite) begin
                unique case (paddr)
                    sac_pkg::OFF_CTRL:   prdata_q <= {24'h0, ctrl_rd};
                    sac_pkg::OFF_CFG:    prdata_q <= {24'h0, cfg_rd};
                    sac_pkg::OFF_RES_HI: prdata_q <= {24'h0, res_hi_q};
                    sac_pkg::OFF_RES_LO: prdata_q <= {24'h0, res_lo_q};
                    default:             prdata_q <= 32'h0;
                endcase
            end
        end
    end

    // control register fields
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            en_q    <= 1'b0;
            dtrk_q  <= 1'b0;
            irqen_q <= 1'b0;
            src_q   <= sac_pkg::SRC_RST;
        end else if (wr_ctrl) begin
            en_q    <= pwdata[sac_pkg::CTRL_EN];
            dtrk_q  <= pwdata[sac_pkg::CTRL_DTRK];
            irqen_q <= pwdata[sac_pkg::CTRL_IRQEN];
            src_q   <= pwdata[sac_pkg::CTRL_SRC_LSB +: 3];
        end
    end

    // config register fields
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q   <= sac_pkg::DIV_RST;
            lj_q    <= sac_pkg::LJ_RST;
            eight_q <= sac_pkg::EIGHT_RST;
        end else if (wr_cfg) begin
            div_q   <= pwdata[sac_pkg::CFG_DIV_LSB +: sac_pkg::DIV_W];
            lj_q    <= pwdata[sac_pkg::CFG_LJ];
            eight_q <= pwdata[sac_pkg::CFG_EIGHT];
        end
    end

    // external start pin: two-flop sync plus edge history
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_convert_start;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    assign ext_rise = ext_s2_q && !ext_s3_q;

    // timer 2/3 overflow byte follows the timer width
    assign t2_ovf = t2_split ? t2_lo_ovf : t2_hi_ovf;
    assign t3_ovf = t3_split ? t3_lo_ovf : t3_hi_ovf;

    assign sw_start = wr_ctrl && pwdata[sac_pkg::CTRL_BUSY];

    // start source select, unused codes never trigger
    always_comb begin
        unique case (src_q)
            sac_pkg::SRC_SW:  trig = sw_start;
            sac_pkg::SRC_T0:  trig = t0_ovf;
            sac_pkg::SRC_T2:  trig = t2_ovf;
            sac_pkg::SRC_T1:  trig = t1_ovf;
            sac_pkg::SRC_EXT: trig = ext_rise;
            sac_pkg::SRC_T3:  trig = t3_ovf;
            default:          trig = 1'b0;
        endcase
    end

    // sar clock divider, restarted at every trigger
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_cnt_q <= 5'h0;
        end else if (!busy || tick) begin
            div_cnt_q <= 5'h0;
        end else begin
            div_cnt_q <= div_cnt_q + 5'h1;
        end
    end
    assign tick = busy && (div_cnt_q == div_q);

    // delayed tracking tick counter
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dly_q <= 2'h0;
        end else if (st_q != sac_pkg::ST_DELAY) begin
            dly_q <= 2'h0;
        end else if (tick) begin
            dly_q <= dly_q + 2'h1;
        end
    end

    // conversion start: at once, or after the third delay tick
    assign core_go = en_q &&
        (((st_q == sac_pkg::ST_IDLE) && trig && !dtrk_q) ||
         ((st_q == sac_pkg::ST_DELAY) && tick &&
          (dly_q == sac_pkg::DELAY_TICKS - 2'h1)));

    // sequencer; disable drops straight to idle
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= sac_pkg::ST_IDLE;
        end else if (!en_q) begin
            st_q <= sac_pkg::ST_IDLE;
        end else begin
            unique case (st_q)
                sac_pkg::ST_IDLE: begin
                    if (trig) begin
                        st_q <= dtrk_q ? sac_pkg::ST_DELAY
                                       : sac_pkg::ST_CONV;
                    end
                end
                sac_pkg::ST_DELAY: begin
                    if (core_go) begin
                        st_q <= sac_pkg::ST_CONV;
                    end
                end
                sac_pkg::ST_CONV: begin
                    if (core_done) begin
                        st_q <= sac_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    sac_sar_core u_core (
        .clk     (clk),
        .rst_n   (rst_n_q),
        .go      (core_go),
        .abort   (!en_q),
        .tick    (tick),
        .eight   (eight_q),
        .cmp_hi  (cmp_hi),
        .trial_q (trial_q),
        .code_q  (core_code),
        .done_q  (core_done)
    );

    // result layout: eight-bit, left or right justified
    always_comb begin
        if (eight_q) begin
            res_fmt = {core_code[9:2], 8'h0};
        end else if (lj_q) begin
            res_fmt = {core_code, 6'h0};
        end else begin
            res_fmt = {6'h0, core_code};
        end
    end

    // result bytes load at the end of every conversion
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            res_hi_q <= 8'h0;
            res_lo_q <= 8'h0;
        end else if (core_done && en_q) begin
            res_hi_q <= res_fmt[15:8];
            res_lo_q <= res_fmt[7:0];
        end
    end

    // done flag: completion wins over a clearing write
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            done_q <= 1'b0;
        end else if (core_done && en_q) begin
            done_q <= 1'b1;
        end else if (wr_ctrl && !pwdata[sac_pkg::CTRL_DONE]) begin
            done_q <= 1'b0;
        end
    end

    // tracking and interrupt outputs
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            track_q <= 1'b0;
            irq_q   <= 1'b0;
        end else begin
            track_q <= en_q && (st_q != sac_pkg::ST_CONV) &&
                       ((src_q != sac_pkg::SRC_EXT) || dtrk_q ||
                        !ext_s2_q);
            irq_q   <= done_q && irqen_q;
        end
    end

    assign prdata   = prdata_q;
    assign pready   = pready_q;
    assign pslverr  = pslverr_q;
    assign dac_code = trial_q;
    assign track    = track_q;
    assign powered  = en_q;
    assign conv_irq = irq_q;

    // helpers: ticks seen in delay and in conversion
    logic [1:0] chk_dly_q;
    logic [3:0] chk_conv_q;
    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            chk_dly_q  <= 2'h0;
            chk_conv_q <= 4'h0;
        end else begin
            chk_dly_q  <= (st_q != sac_pkg::ST_DELAY) ? 2'h0 :
                          chk_dly_q + 2'(tick);
            chk_conv_q <= (st_q != sac_pkg::ST_CONV) ? 4'h0 :
                          chk_conv_q + 4'(tick);
        end
    end

    chk_off_idle: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        !en_q |=> !busy && !core_done ##1 !core_done)
    else $error("conversion activity while disabled");

    chk_done_sets: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        core_done && en_q |=> done_q && !busy ##1 (irq_q == irqen_q))
    else $error("completion did not set done and irq");

    chk_right_just: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        core_done && en_q && !eight_q && !lj_q |=>
        {res_hi_q, res_lo_q} == {6'h0, $past(core_code)})
    else $error("right justified result wrong");

    chk_left_just: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        core_done && en_q && !eight_q && lj_q |=>
        {res_hi_q, res_lo_q} == {$past(core_code), 6'h0})
    else $error("left justified result wrong");

    chk_eight_bit: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        core_done && en_q && eight_q |=>
        res_lo_q == 8'h0 && res_hi_q == $past(core_code[9:2]))
    else $error("eight-bit result wrong");

    chk_delay_three: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        $past(st_q) == sac_pkg::ST_DELAY && st_q == sac_pkg::ST_CONV
        |-> chk_dly_q == sac_pkg::DELAY_TICKS)
    else $error("delayed start not after three ticks");

    chk_no_delay: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        en_q && !busy && trig && !dtrk_q |=> st_q == sac_pkg::ST_CONV)
    else $error("immediate start did not convert");

    chk_conv_len: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        core_done && en_q |-> chk_conv_q ==
        (eight_q ? sac_pkg::TICKS_EIGHT : sac_pkg::TICKS_TEN))
    else $error("conversion length wrong");

    chk_no_track_conv: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        st_q == sac_pkg::ST_CONV |=> !track_q)
    else $error("tracking while converting");

    chk_ext_pin_hold: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        en_q && src_q == sac_pkg::SRC_EXT && !dtrk_q && ext_s2_q
        |=> !track_q)
    else $error("tracking with start pin high");

    chk_sw_start: assert property (
        @(posedge clk) disable iff (!rst_n_q)
        en_q && !busy && src_q == sac_pkg::SRC_SW && sw_start |=> busy)
    else $error("software start ignored");
endmodule
`default_nettype wire

// *** design/sac_pkg.sv ***
/*
 * sac_pkg: shared constants and types of the SAR converter control block.
 * Assumes a single 50 MHz system clock and an APB register interface.
 */
`default_nettype none
package sac_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_CFG    = 8'h04;
    localparam logic [7:0] OFF_RES_HI = 8'h08;
    localparam logic [7:0] OFF_RES_LO = 8'h0c;

    // control register fields
    localparam int unsigned CTRL_SRC_LSB = 0;
    localparam int unsigned CTRL_IRQEN   = 3;
    localparam int unsigned CTRL_BUSY    = 4;
    localparam int unsigned CTRL_DONE    = 5;
    localparam int unsigned CTRL_DTRK    = 6;
    localparam int unsigned CTRL_EN      = 7;

    // config register fields
    localparam int unsigned CFG_EIGHT   = 1;
    localparam int unsigned CFG_LJ      = 2;
    localparam int unsigned CFG_DIV_LSB = 3;

    // values after reset
    localparam logic [4:0] DIV_RST   = 5'h1f;
    localparam logic       LJ_RST    = 1'b0;
    localparam logic       EIGHT_RST = 1'b0;
    localparam logic [2:0] SRC_RST   = 3'h0;

    // conversion geometry and timing
    localparam int unsigned CODE_W  = 10;
    localparam int unsigned EIGHT_W = 8;
    localparam int unsigned DIV_W   = 5;
    localparam logic [1:0]  DELAY_TICKS = 2'h3;
    localparam logic [3:0]  TICKS_TEN   = 4'ha;
    localparam logic [3:0]  TICKS_EIGHT = 4'h8;

    // start-of-conversion sources, codes 0 to 5 in order
    typedef enum logic [2:0] {
        SRC_SW, SRC_T0, SRC_T2, SRC_T1, SRC_EXT, SRC_T3
    } sac_src_t;

    // conversion sequencer states
    typedef enum logic [1:0] {
        ST_IDLE, ST_DELAY, ST_CONV
    } sac_state_t;
endpackage
`default_nettype wire

// *** design/sac_sar_core.sv ***
/*
 * sac_sar_core: successive approximation register and bit sequencer.
 * Assumes cmp_hi is valid for the current trial code at every tick and
 * that go and tick never come in the same cycle as a pending tick.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_sar_core (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      go,
    input  wire logic                      abort,
    input  wire logic                      tick,
    input  wire logic                      eight,
    input  wire logic                      cmp_hi,
    output logic [sac_pkg::CODE_W-1:0]     trial_q,
    output logic [sac_pkg::CODE_W-1:0]     code_q,
    output logic                           done_q
);
    logic       active_q;
    logic [3:0] idx_q;
    logic       last;
    logic [sac_pkg::CODE_W-1:0] trial_d;

    // eight-bit runs stop two bits early
    assign last = eight ? (idx_q == 4'(sac_pkg::CODE_W - sac_pkg::EIGHT_W))
                        : (idx_q == 4'h0);

    // resolve the current bit, then try the next lower one
    always_comb begin
        trial_d = trial_q;
        trial_d[idx_q] = cmp_hi;
        if (!last) begin
            trial_d[idx_q - 4'h1] = 1'b1;
        end
    end

    // bit walk, msb first, one bit per sar clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_q <= 1'b0;
            idx_q    <= 4'h0;
            trial_q  <= '0;
            code_q   <= '0;
            done_q   <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                active_q <= 1'b0;
                trial_q  <= '0;
            end else if (go) begin
                active_q <= 1'b1;
                idx_q    <= 4'(sac_pkg::CODE_W - 1);
                trial_q  <= {1'b1, {(sac_pkg::CODE_W-1){1'b0}}};
            end else if (active_q && tick) begin
                if (last) begin
                    active_q <= 1'b0;
                    code_q   <= trial_d;
                    trial_q  <= '0;
                    done_q   <= 1'b1;
                end else begin
                    idx_q   <= idx_q - 4'h1;
                    trial_q <= trial_d;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** test/sac_cmp_model.sv ***
/*
 * sac_cmp_model: far side of the converter, an ideal comparator.
 * Assumes vin holds still for the whole of a conversion.
 */
`timescale 1ns/1ps
`default_nettype none
module sac_cmp_model (
    input  wire logic [9:0] vin,
    input  wire logic [9:0] dac_code,
    output logic            cmp_hi
);
    // high while the held input is at or above the trial code
    assign cmp_hi = (vin >= dac_code);
endmodule
`default_nettype wire

// *** test/tb.sv ***
/*
 * tb: self-checking bench of sac_conv_ctrl, registers reached over APB.
 * Assumes the ideal comparator model and a 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module tb;
    typedef struct {
        logic [2:0]  src;
        logic [4:0]  div;
        logic        eight;
        logic        lj;
        logic        dt;
        int          pi;
        int          wi;
        logic [9:0]  v;
        logic [15:0] res;
    } sac_row_t;
    localparam logic [7:0] A_CTL = sac_pkg::OFF_CTRL;
    localparam logic [7:0] A_CFG = sac_pkg::OFF_CFG;
    logic        clk;
    logic        rstn;
    logic [7:0]  paddr;
    logic        psel, penable, pwrite, pready, pslverr, er;
    logic [31:0] pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [5:0]  ovf;
    logic        t2_split, t3_split, ext, cmp_hi;
    logic [9:0]  dac_code, vin;
    logic [7:0]  hb;
    logic        track, powered, conv_irq;
    int          failures, cmp_count, l0, n0, l1, n1;
    sac_row_t    rows [6];

    sac_conv_ctrl sac_conv_ctrl_inst (
        .clk(clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .t0_ovf(ovf[0]), .t1_ovf(ovf[1]),
        .t2_lo_ovf(ovf[2]), .t2_hi_ovf(ovf[3]), .t2_split(t2_split),
        .t3_lo_ovf(ovf[4]), .t3_hi_ovf(ovf[5]), .t3_split(t3_split),
        .ext_convert_start(ext), .cmp_hi(cmp_hi), .dac_code(dac_code),
        .track(track), .powered(powered), .conv_irq(conv_irq));
    sac_cmp_model sac_cmp_model_inst (
        .vin(vin), .dac_code(dac_code), .cmp_hi(cmp_hi));

    // 50 mhz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    function automatic logic [31:0] ctl(logic en, logic dt, logic go,
                                        logic [2:0] s);
        return {24'h000000, en, dt, 1'b0, go, 1'b1, s};
    endfunction
    function automatic logic [31:0] cfg(logic [4:0] d, logic lj, logic e);
        return {24'h000000, d, lj, e, 1'b0};
    endfunction

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // wait as long as it takes; the watchdog ends a hang
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one-cycle overflow pulse, index 6 or 7 pulses nothing
    task automatic pulse(input int i);
        @(posedge clk);
        ovf <= 6'(1 << i);
        @(posedge clk);
        ovf <= 6'h00;
    endtask

    // poll the done flag before the results are read
    task automatic wait_done();
        for (int i = 0; i < 200; i++) begin
            apb(1'b0, A_CTL, 32'h0);
            if (r[5] === 1'b1) break;
        end
    endtask

    // one triggered conversion from a table row
    task automatic conv(input sac_row_t w);
        vin <= w.v;
        apb(1'b1, A_CFG, cfg(w.div, w.lj, w.eight));
        apb(1'b1, A_CTL, ctl(1'b1, w.dt, 1'b0, w.src));
        pulse(w.wi);
        apb(1'b0, A_CTL, 32'h0);
        `CHK(r[4], 1'b0)
        if (w.src == 3'h0) apb(1'b1, A_CTL, ctl(1'b1, w.dt, 1'b1, 3'h0));
        else if (w.src == 3'h4) begin
            ext <= 1'b1;
            repeat (6) @(posedge clk);
            ext <= 1'b0;
        end else pulse(w.pi);
        wait_done();
        `CHK(r[5:4], 2'b10)
        `CHK(conv_irq, 1'b1)
        apb(1'b0, sac_pkg::OFF_RES_HI, 32'h0);
        hb = r[7:0];
        apb(1'b0, sac_pkg::OFF_RES_LO, 32'h0);
        `CHK({hb, r[7:0]}, w.res)
        `CHK(track, 1'b1)
        apb(1'b1, A_CTL, ctl(1'b1, w.dt, 1'b0, w.src));
        apb(1'b0, A_CTL, 32'h0);
        `CHK(r[5], 1'b0)
    endtask

    // time a t0 conversion: trigger to first trial, then its length
    task automatic meas(input logic [4:0] dv, input logic e,
                        input logic dt, output int lat, output int len);
        apb(1'b1, A_CFG, cfg(dv, 1'b0, e));
        apb(1'b1, A_CTL, ctl(1'b1, dt, 1'b0, 3'h1));
        pulse(0);
        lat = 0;
        len = 0;
        while (dac_code === 10'h000 && lat < 500) begin
            @(posedge clk);
            lat++;
        end
        while (dac_code !== 10'h000 && len < 500) begin
            @(posedge clk);
            len++;
        end
        wait_done();
        `CHK(lat < 500 && len < 500, 1'b1)
        `CHK(r[5], 1'b1)
        apb(1'b1, A_CTL, ctl(1'b1, dt, 1'b0, 3'h1));
    endtask

    task automatic results();
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #1ms;
        failures++;
        results();
    end

    // main sequence
    initial begin
        rstn = 1'b0;
        {psel, penable, pwrite, ext} = 4'h0;
        {paddr, pwdata, pstrb, ovf, vin} = '0;
        pstrb = 4'hf;
        {t2_split, t3_split} = 2'b10;
        failures = 0;
        cmp_count = 0;
        rows = '{'{3'h0, 5'h00, 1'b0, 1'b0, 1'b0, 7, 0, 10'h3ff, 16'h03ff},
                 '{3'h1, 5'h01, 1'b0, 1'b1, 1'b0, 0, 1, 10'h200, 16'h8000},
                 '{3'h2, 5'h00, 1'b0, 1'b1, 1'b1, 2, 3, 10'h100, 16'h4000},
                 '{3'h3, 5'h02, 1'b1, 1'b1, 1'b0, 1, 0, 10'h3ff, 16'hff00},
                 '{3'h4, 5'h00, 1'b0, 1'b0, 1'b0, 7, 5, 10'h200, 16'h0200},
                 '{3'h5, 5'h00, 1'b1, 1'b0, 1'b0, 5, 4, 10'h155, 16'h5500}};
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values and an unmapped address
        apb(1'b0, A_CTL, 32'h0);
        `CHK({powered, r}, 33'h000000000)
        apb(1'b0, A_CFG, 32'h0);
        `CHK(r, 32'h000000f8)
        apb(1'b0, 8'h10, 32'h0);
        `CHK({er, r}, 33'h100000000)
        foreach (rows[k]) conv(rows[k]);
        // eight-bit drops two ticks, delay adds three
        vin <= 10'h2aa;
        meas(5'h03, 1'b0, 1'b0, l0, n0);
        meas(5'h03, 1'b1, 1'b0, l1, n1);
        `CHK(n0 - n1, 8)
        meas(5'h03, 1'b0, 1'b1, l1, n1);
        `CHK(l1 - l0, 12)
        // enable clear: no conversion, then abort mid-run
        apb(1'b1, A_CTL, ctl(1'b0, 1'b0, 1'b0, 3'h1));
        pulse(0);
        repeat (20) @(posedge clk);
        `CHK({powered, dac_code}, 11'h000)
        apb(1'b1, A_CFG, cfg(5'h1f, 1'b0, 1'b0));
        apb(1'b1, A_CTL, ctl(1'b1, 1'b0, 1'b0, 3'h1));
        pulse(0);
        repeat (40) @(posedge clk);
        apb(1'b1, A_CTL, ctl(1'b0, 1'b0, 1'b0, 3'h1));
        repeat (400) @(posedge clk);
        apb(1'b0, A_CTL, 32'h0);
        `CHK(r[5:4], 2'b00)
        // unused source code: a timer pulse must not start anything
        apb(1'b1, A_CTL, ctl(1'b1, 1'b0, 1'b0, 3'h6));
        pulse(0);
        apb(1'b0, A_CTL, 32'h0);
        `CHK(r[7:0], 8'h8e)
        // external source: tracking follows the pin or the delay bit
        apb(1'b1, A_CFG, cfg(5'h00, 1'b0, 1'b0));
        apb(1'b1, A_CTL, ctl(1'b1, 1'b0, 1'b0, 3'h4));
        ext <= 1'b1;
        repeat (40) @(posedge clk);
        `CHK(track, 1'b0)
        apb(1'b1, A_CTL, ctl(1'b1, 1'b1, 1'b0, 3'h4));
        repeat (3) @(posedge clk);
        `CHK(track, 1'b1)
        results();
    end
endmodule
`default_nettype wire
